// *** serial_port_pkg.sv ***
package serial_port_pkg;
	// Register indices on the plain port
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_TX_DATA = 4'h1;
	localparam logic [3:0] ADDR_RX_DATA = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
	localparam logic [3:0] ADDR_PIN_CONTROL = 4'h5;
	// Control register field positions
	localparam int TX_EMPTY_BIT = 18;
	localparam int TX_READY_BIT = 17;
	localparam int TX_ENABLE_BIT = 16;
	localparam int LOOPBACK_BIT = 15;
	localparam int JUSTIFY_HI = 14;
	localparam int JUSTIFY_LO = 13;
	localparam int CLKSTOP_HI = 12;
	localparam int CLKSTOP_LO = 11;
	localparam int DATA_OUT_EN_BIT = 7;
	localparam int IRQ_SEL_HI = 5;
	localparam int IRQ_SEL_LO = 4;
	localparam int SYNC_ERR_BIT = 3;
	localparam int OVERRUN_BIT = 2;
	localparam int RX_READY_BIT = 1;
	localparam int RX_ENABLE_BIT = 0;
	// Pin control register: transmit clock polarity
	localparam int CLK_POL_BIT = 0;
	// Interrupt status bits
	localparam int IRQ_RX_EVENT = 0;
	localparam int IRQ_OVERRUN = 1;
	localparam int IRQ_TX_READY = 2;
	localparam int IRQ_BITS = 3;
	localparam logic [1:0] JUSTIFY_RIGHT_ZERO = 2'h0;
	localparam logic [1:0] JUSTIFY_RIGHT_SIGN = 2'h1;
	localparam logic [1:0] JUSTIFY_LEFT_ZERO = 2'h2;
	localparam logic [1:0] CLKSTOP_OFF = 2'h0;
	localparam logic [1:0] CLKSTOP_NODELAY = 2'h2;
	localparam logic [1:0] CLKSTOP_DELAY = 2'h3;
	localparam logic [1:0] IRQSEL_BLOCK = 2'h1;
	localparam logic [1:0] IRQSEL_FRAME = 2'h2;
	localparam logic [1:0] IRQSEL_SYNCERR = 2'h3;
	// Serial clock half period in device clocks (250 MHz)
	localparam int CLK_HALF_CYCLES = 4;
	localparam int WORD_BITS = 8;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_DELAY = 3'b010,
		TX_SHIFT = 3'b100
	} tx_state_t;
endpackage

// *** edge_finder.sv ***
`timescale 1ns/100ps
// Two-flop synchroniser plus edge detect for one outside level
module edge_finder
(
	input wire logic clk,
	input wire logic reset,
	input wire logic enable,
	input wire logic pinIn,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic last;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end
		else if (enable)
		begin
			meta <= pinIn;
			sync <= meta;
			last <= sync;
		end
	end
	assign level = sync;
	assign rise = sync & ~last;
	assign fall = ~sync & last;
endmodule

// *** serial_port_control_status.sv ***
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// How it works
// - Bit 18 shows transmit shifter holds data
// - Bit 17 set when transmit register free and bit 16 set
// - Bit 16 low holds transmitter in reset
// - Bit 15 selects digital loopback
// - Bits 14-13 set receive justification
// - Clock-stop 0 normal clocking; 1 reserved
// - Rising polarity: 2 rise first, 3 delayed
// - Falling polarity: 2 falls, 3 delayed fall
// - Reserved bits read zero, ignore writes
// - Bits 5-4 choose receive interrupt source
// - Bit 3 sync error; write forces if enabled
// - Bit 2 overrun when all receive stages full
// - Bit 1 low while nothing to read
// - Bit 1 high when receive word available
// - Bit 0 low holds receiver in reset
module serial_port_control_status
#(
	parameter int WORD_BITS = serial_port_pkg::WORD_BITS,
	parameter int HALF_CYCLES = serial_port_pkg::CLK_HALF_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEnable,
	input wire logic [3:0] address,
	input wire logic [31:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [31:0] readData,
	output logic irq,
	output logic rxInterrupt,
	input wire logic rxDataPin,
	input wire logic rxClockPin,
	input wire logic rxFramePin,
	output logic txDataPin,
	output logic txDataPinOe_n,
	output logic txClockPin,
	output logic txFramePin
);
	initial
	begin
		if (WORD_BITS < 2 || WORD_BITS > 32 || HALF_CYCLES < 1 || HALF_CYCLES > 256)
			$error("serial_port_control_status: unsupported parameters");
	end

	// Writable control fields and sticky interrupt status
	logic txEnable;
	logic loopbackEnable;
	logic [1:0] justifyMode;
	logic [1:0] clockStopMode;
	logic dataOutEnabler;
	logic [1:0] irqSourceSelect;
	logic rxEnable;
	logic txClockPolarity;
	logic [serial_port_pkg::IRQ_BITS-1:0] irqStatus;
	logic [serial_port_pkg::IRQ_BITS-1:0] irqMask;
	// Transmit path
	logic [WORD_BITS-1:0] txDataReg;
	logic txDataFull;
	logic [WORD_BITS-1:0] txShift;
	logic [5:0] txBitCount;
	logic [7:0] halfCount;
	serial_port_pkg::tx_state_t txState;
	logic sclk;
	// Receive path
	logic [WORD_BITS-1:0] rxShift;
	logic [5:0] rxBitCount;
	logic [WORD_BITS-1:0] rxBuffer;
	logic rxBufferFull;
	logic [WORD_BITS-1:0] rxDataReg;
	logic rxReady;
	logic overrun;
	logic syncError;
	logic rxInFrame;
	logic rxWordDone;

	wire ctrlWrite = writeStrobe && address == serial_port_pkg::ADDR_CONTROL;
	wire txWrite = writeStrobe && address == serial_port_pkg::ADDR_TX_DATA;
	wire rxRead = readStrobe && address == serial_port_pkg::ADDR_RX_DATA;
	wire statusRead = readStrobe && address == serial_port_pkg::ADDR_IRQ_STATUS;

	// External receive pins pass two flops before use
	logic extData, extClkRise, extClkFall, extFrameRise;
	edge_finder dataSync (.clk(clk), .reset(reset), .enable(clkEnable), .pinIn(rxDataPin),
		.level(extData), .rise(), .fall());
	edge_finder clkSync (.clk(clk), .reset(reset), .enable(clkEnable), .pinIn(rxClockPin),
		.level(), .rise(extClkRise), .fall(extClkFall));
	edge_finder frameSync (.clk(clk), .reset(reset), .enable(clkEnable), .pinIn(rxFramePin),
		.level(), .rise(extFrameRise), .fall());

	// Internal transmit clock edges, already in this domain
	wire halfDone = txState != serial_port_pkg::TX_IDLE && halfCount == 8'(HALF_CYCLES - 1);
	wire intClkRise = halfDone && !sclk && txState == serial_port_pkg::TX_SHIFT;
	wire intClkFall = halfDone && sclk && txState == serial_port_pkg::TX_SHIFT;
	wire intFrame = txState == serial_port_pkg::TX_IDLE && txDataFull && txEnable;
	// A delayed start with rising-edge sampling rests high so that its first edge falls
	wire idleLevel = txClockPolarity || clockStopMode == serial_port_pkg::CLKSTOP_DELAY;
	wire sampleEdge = sclk == txClockPolarity;

	// Loopback bypasses the pins entirely
	wire rxBit = loopbackEnable ? txShift[WORD_BITS-1] : extData;
	wire rxSample = loopbackEnable ? (txClockPolarity ? intClkFall : intClkRise)
		: (txClockPolarity ? extClkFall : extClkRise);
	wire rxFrameStart = loopbackEnable ? intFrame : extFrameRise;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txEnable <= 1'b0;
			loopbackEnable <= 1'b0;
			justifyMode <= serial_port_pkg::JUSTIFY_RIGHT_ZERO;
			clockStopMode <= serial_port_pkg::CLKSTOP_OFF;
			dataOutEnabler <= 1'b0;
			irqSourceSelect <= 2'h0;
			rxEnable <= 1'b0;
			txClockPolarity <= 1'b0;
			irqMask <= '0;
		end
		else if (clkEnable && writeStrobe)
		begin
			if (address == serial_port_pkg::ADDR_CONTROL)
			begin
				// Status and reserved positions are simply not stored
				txEnable <= writeData[serial_port_pkg::TX_ENABLE_BIT];
				loopbackEnable <= writeData[serial_port_pkg::LOOPBACK_BIT];
				justifyMode <= writeData[serial_port_pkg::JUSTIFY_HI:serial_port_pkg::JUSTIFY_LO];
				clockStopMode <= writeData[serial_port_pkg::CLKSTOP_HI:serial_port_pkg::CLKSTOP_LO];
				dataOutEnabler <= writeData[serial_port_pkg::DATA_OUT_EN_BIT];
				irqSourceSelect <= writeData[serial_port_pkg::IRQ_SEL_HI:serial_port_pkg::IRQ_SEL_LO];
				rxEnable <= writeData[serial_port_pkg::RX_ENABLE_BIT];
			end
			if (address == serial_port_pkg::ADDR_PIN_CONTROL)
				txClockPolarity <= writeData[serial_port_pkg::CLK_POL_BIT];
			if (address == serial_port_pkg::ADDR_IRQ_MASK)
				irqMask <= writeData[serial_port_pkg::IRQ_BITS-1:0];
		end
	end

	// Transmit data register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txDataReg <= '0;
			txDataFull <= 1'b0;
		end
		else if (clkEnable)
		begin
			if (!txEnable)
				txDataFull <= 1'b0;
			else if (txWrite)
			begin
				txDataReg <= writeData[WORD_BITS-1:0];
				txDataFull <= 1'b1;
			end
			else if (intFrame)
				txDataFull <= 1'b0;
		end
	end

	// Transmit shifter and serial clock generator
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txState <= serial_port_pkg::TX_IDLE;
			txShift <= '0;
			txBitCount <= '0;
			halfCount <= '0;
			sclk <= 1'b0;
		end
		else if (clkEnable)
		begin
			if (!txEnable)
			begin
				txState <= serial_port_pkg::TX_IDLE;
				txBitCount <= '0;
				halfCount <= '0;
				sclk <= idleLevel;
			end
			else
			begin
				case (txState)
					serial_port_pkg::TX_IDLE:
					begin
						// Idle level: clock rests at its quiet level
						sclk <= idleLevel;
						halfCount <= '0;
						if (intFrame)
						begin
							txShift <= txDataReg;
							txBitCount <= 6'(WORD_BITS);
							// Delayed mode adds half a period: first edge comes a full period after load
							if (clockStopMode == serial_port_pkg::CLKSTOP_DELAY)
								txState <= serial_port_pkg::TX_DELAY;
							else
								txState <= serial_port_pkg::TX_SHIFT;
						end
					end
					serial_port_pkg::TX_DELAY:
					begin
						halfCount <= halfCount + 8'h01;
						if (halfDone)
						begin
							halfCount <= '0;
							txState <= serial_port_pkg::TX_SHIFT;
						end
					end
					serial_port_pkg::TX_SHIFT:
					begin
						halfCount <= halfCount + 8'h01;
						if (halfDone)
						begin
							halfCount <= '0;
							sclk <= ~sclk;
							if (sampleEdge)
							begin
								txBitCount <= txBitCount - 6'h01;
								// A high resting clock with rising-edge sampling ends on its last sampling edge
								if (txBitCount == 6'h01 && ~sclk == idleLevel)
									txState <= serial_port_pkg::TX_IDLE;
							end
							else if (txBitCount == 6'h00)
								txState <= serial_port_pkg::TX_IDLE;
							// No shift before the first sample: the top bit must be seen
							else if (txBitCount != 6'(WORD_BITS))
								txShift <= {txShift[WORD_BITS-2:0], 1'b0};
						end
					end
					default:
						txState <= serial_port_pkg::TX_IDLE;
				endcase
			end
		end
	end

	wire txShifterBusy = txState != serial_port_pkg::TX_IDLE;

	// Receive shifter, buffer and data register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rxShift <= '0;
			rxBitCount <= '0;
			rxInFrame <= 1'b0;
			rxWordDone <= 1'b0;
			rxBuffer <= '0;
			rxBufferFull <= 1'b0;
			rxDataReg <= '0;
			rxReady <= 1'b0;
			overrun <= 1'b0;
		end
		else if (clkEnable)
		begin
			rxWordDone <= 1'b0;
			if (!rxEnable)
			begin
				rxInFrame <= 1'b0;
				rxBitCount <= '0;
				rxBufferFull <= 1'b0;
				rxReady <= 1'b0;
				overrun <= 1'b0;
			end
			else
			begin
				if (rxFrameStart)
				begin
					rxInFrame <= 1'b1;
					rxBitCount <= '0;
				end
				else if (rxInFrame && rxSample)
				begin
					rxShift <= {rxShift[WORD_BITS-2:0], rxBit};
					rxBitCount <= rxBitCount + 6'h01;
					if (rxBitCount == 6'(WORD_BITS - 1))
					begin
						rxInFrame <= 1'b0;
						rxWordDone <= 1'b1;
					end
				end
				// Word moves shifter to buffer; buffer to data register when that is empty or read
				if (rxWordDone)
				begin
					if (!rxBufferFull || !rxReady)
					begin
						rxBuffer <= rxShift;
						rxBufferFull <= 1'b1;
					end
					else
						overrun <= 1'b1;
				end
				else if (rxBufferFull && (!rxReady || rxRead))
				begin
					rxDataReg <= rxBuffer;
					rxBufferFull <= 1'b0;
					rxReady <= 1'b1;
					overrun <= 1'b0;
				end
				else if (rxRead)
				begin
					rxReady <= 1'b0;
					overrun <= 1'b0;
				end
			end
		end
	end

	// Justification of the received word
	logic [31:0] rxJustified;
	always_comb
	begin
		rxJustified = '0;
		case (justifyMode)
			serial_port_pkg::JUSTIFY_RIGHT_SIGN:
				rxJustified = 32'($signed(rxDataReg));
			serial_port_pkg::JUSTIFY_LEFT_ZERO:
				rxJustified = {rxDataReg, {(32 - WORD_BITS){1'b0}}};
			default:
				rxJustified = 32'(rxDataReg);
		endcase
	end

	// Frame sync error: a new frame arriving mid-word; writes may force it
	wire forceSync = ctrlWrite && writeData[serial_port_pkg::SYNC_ERR_BIT] && rxEnable;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			syncError <= 1'b0;
		else if (clkEnable)
		begin
			if (!rxEnable)
				syncError <= 1'b0;
			else if ((rxFrameStart && rxInFrame) || forceSync)
				syncError <= 1'b1;
			else if (ctrlWrite)
				syncError <= 1'b0;
		end
	end

	// Receive interrupt source selection
	logic rxEvent;
	always_comb
	begin
		case (irqSourceSelect)
			serial_port_pkg::IRQSEL_BLOCK: rxEvent = rxWordDone;
			serial_port_pkg::IRQSEL_FRAME: rxEvent = rxFrameStart && rxEnable;
			serial_port_pkg::IRQSEL_SYNCERR: rxEvent = syncError;
			default: rxEvent = 1'b0;
		endcase
	end

	wire [serial_port_pkg::IRQ_BITS-1:0] irqEvents = {txWrite == 1'b0 && txEnable
		&& !txDataFull, rxWordDone && rxReady && rxBufferFull, rxEvent};

	// Sticky status: events win over the read that clears
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			irqStatus <= '0;
			irq <= 1'b0;
			rxInterrupt <= 1'b0;
		end
		else if (clkEnable)
		begin
			irqStatus <= (statusRead ? '0 : irqStatus) | irqEvents;
			irq <= |(irqStatus & irqMask);
			rxInterrupt <= rxEvent;
		end
	end

	// Control register readback
	logic [31:0] controlView;
	always_comb
	begin
		controlView = '0;
		controlView[serial_port_pkg::TX_EMPTY_BIT] = txShifterBusy;
		controlView[serial_port_pkg::TX_READY_BIT] = txEnable && !txDataFull;
		controlView[serial_port_pkg::TX_ENABLE_BIT] = txEnable;
		controlView[serial_port_pkg::LOOPBACK_BIT] = loopbackEnable;
		controlView[serial_port_pkg::JUSTIFY_HI:serial_port_pkg::JUSTIFY_LO] = justifyMode;
		controlView[serial_port_pkg::CLKSTOP_HI:serial_port_pkg::CLKSTOP_LO] = clockStopMode;
		controlView[serial_port_pkg::DATA_OUT_EN_BIT] = dataOutEnabler;
		controlView[serial_port_pkg::IRQ_SEL_HI:serial_port_pkg::IRQ_SEL_LO] = irqSourceSelect;
		controlView[serial_port_pkg::SYNC_ERR_BIT] = syncError;
		controlView[serial_port_pkg::OVERRUN_BIT] = overrun;
		controlView[serial_port_pkg::RX_READY_BIT] = rxReady;
		controlView[serial_port_pkg::RX_ENABLE_BIT] = rxEnable;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			readData <= '0;
		else if (clkEnable)
		begin
			readData <= '0;
			if (readStrobe)
			begin
				case (address)
					serial_port_pkg::ADDR_CONTROL: readData <= controlView;
					serial_port_pkg::ADDR_TX_DATA: readData <= 32'(txDataReg);
					serial_port_pkg::ADDR_RX_DATA: readData <= rxJustified;
					serial_port_pkg::ADDR_IRQ_STATUS: readData <= 32'(irqStatus);
					serial_port_pkg::ADDR_IRQ_MASK: readData <= 32'(irqMask);
					serial_port_pkg::ADDR_PIN_CONTROL: readData <= 32'(txClockPolarity);
					default: readData <= '0;
				endcase
			end
		end
	end

	// Pin outputs, registered
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txDataPin <= 1'b0;
			txDataPinOe_n <= 1'b1;
			txClockPin <= 1'b0;
			txFramePin <= 1'b0;
		end
		else if (clkEnable)
		begin
			txDataPin <= txShift[WORD_BITS-1];
			// Enabler keeps the pin driven between words as well
			txDataPinOe_n <= !(txShifterBusy || (dataOutEnabler && txEnable)) || loopbackEnable;
			txClockPin <= sclk;
			txFramePin <= intFrame;
		end
	end

	tx_ready_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && !txEnable |=> !txDataFull && !txShifterBusy)
		else $error("transmitter active while held in reset");
	rx_reset_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && !rxEnable |=> !rxReady && !overrun)
		else $error("receiver flags set while in reset");
	overrun_cause_a: assert property (@(posedge clk) disable iff (reset)
		$rose(overrun) |-> $past(rxReady) && $past(rxBufferFull))
		else $error("overrun without full receive stages");
	empty_read_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && rxRead && !rxBufferFull && !rxWordDone && rxEnable |=> !rxReady)
		else $error("receiver ready after read of last word");
	irq_level_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && |(irqStatus & irqMask) |=> irq)
		else $error("interrupt not raised for unmasked status");
	sync_force_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && forceSync |=> syncError)
		else $error("forced sync error not set");
	reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && readStrobe && address == serial_port_pkg::ADDR_CONTROL
		|=> readData[10:8] == 3'h0 && !readData[6])
		else $error("reserved control bits read non-zero");
	shifter_flag_a: assert property (@(posedge clk) disable iff (reset)
		clkEnable && intFrame |=> txShifterBusy)
		else $error("shifter not busy after load");
endmodule

// *** serial_codec_model.sv ***
`timescale 1ns/100ps
// Far-side codec: one framed word per call, clock still between frames
module serial_codec_model
#(
	parameter int WORD_BITS = 8,
	parameter real QUARTER_NS = 31.25
)
(
	output logic dataOut,
	output logic clockOut,
	output logic frameOut
);
	initial
	begin
		dataOut = 1'b0;
		clockOut = 1'b0;
		frameOut = 1'b0;
	end
	// Both clock edges fall mid-bit, so either sampling polarity sees settled data
	task automatic sendWord(input logic [WORD_BITS-1:0] word, input int gapQuarters);
		#(gapQuarters * QUARTER_NS);
		frameOut = 1'b1;
		#(4 * QUARTER_NS);
		frameOut = 1'b0;
		for (int i = WORD_BITS - 1; i >= 0; i--)
		begin
			dataOut = word[i];
			#(QUARTER_NS);
			clockOut = 1'b1;
			#(2 * QUARTER_NS);
			clockOut = 1'b0;
			#(QUARTER_NS);
		end
		// Released line has no pull, so it must not keep showing the last bit
		dataOut = ~word[0];
	endtask
endmodule

// *** serial_port_control_status_bench.sv ***
`timescale 1ns/100ps
`define CHECK(got, exp) \
	begin \
		nTests++; \
		if ((got) !== (exp)) \
		begin \
			nFail++; \
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module serial_port_control_status_bench;
	typedef struct {
		logic [1:0] justify;
		logic [1:0] stopMode;
		logic polarity;
		logic [7:0] word;
		logic [31:0] rxWord;
		logic firstRise;
	} row_t;
	localparam logic [3:0] CTRL = serial_port_pkg::ADDR_CONTROL;
	localparam logic [3:0] TXD = serial_port_pkg::ADDR_TX_DATA;
	localparam logic [3:0] RXD = serial_port_pkg::ADDR_RX_DATA;
	localparam logic [3:0] IST = serial_port_pkg::ADDR_IRQ_STATUS;
	localparam logic [3:0] MSK = serial_port_pkg::ADDR_IRQ_MASK;
	localparam logic [3:0] PIN = serial_port_pkg::ADDR_PIN_CONTROL;
	logic clk, reset, clkEnable, writeStrobe, readStrobe, lvl, lastClk, lastIrq;
	logic [3:0] address;
	logic [31:0] writeData, readData, rd;
	logic irq, rxInterrupt, txDataPin, txDataPinOe_n, txClockPin, txFramePin;
	logic rxDataPin, rxClockPin, rxFramePin;
	int nFail = 0;
	int nTests = 0;
	int clkEdges = 0;
	int rxIrqCount = 0;
	int k, n, f, lastDelay;
	int frames = 0;
	logic [7:0] txBits;
	row_t rows [8] = '{
		'{2'h0, 2'h0, 1'b0, 8'hA5, 32'h0000_00A5, 1'b0},
		'{2'h1, 2'h0, 1'b0, 8'hA5, 32'hFFFF_FFA5, 1'b0},
		'{2'h1, 2'h0, 1'b0, 8'h5A, 32'h0000_005A, 1'b0},
		'{2'h2, 2'h0, 1'b0, 8'hA5, 32'hA500_0000, 1'b0},
		'{2'h0, 2'h2, 1'b0, 8'h3C, 32'h0000_003C, 1'b1},
		'{2'h0, 2'h3, 1'b0, 8'hC3, 32'h0000_00C3, 1'b0},
		'{2'h0, 2'h2, 1'b1, 8'h81, 32'h0000_0081, 1'b0},
		'{2'h0, 2'h3, 1'b1, 8'h7E, 32'h0000_007E, 1'b0}
	};
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	serial_port_control_status #(.WORD_BITS(8), .HALF_CYCLES(4)) dut (.clk(clk), .reset(reset),
		.clkEnable(clkEnable), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .irq(irq),
		.rxInterrupt(rxInterrupt), .rxDataPin(rxDataPin), .rxClockPin(rxClockPin),
		.rxFramePin(rxFramePin), .txDataPin(txDataPin), .txDataPinOe_n(txDataPinOe_n),
		.txClockPin(txClockPin), .txFramePin(txFramePin));
	serial_codec_model #(.WORD_BITS(8)) partner (.dataOut(rxDataPin), .clockOut(rxClockPin),
		.frameOut(rxFramePin));
	always @(posedge clk)
	begin
		lastClk <= txClockPin;
		lastIrq <= rxInterrupt;
		if (lastClk !== txClockPin)
			clkEdges++;
		if (rxInterrupt === 1'b1 && lastIrq === 1'b0)
			rxIrqCount++;
		// Pin data is captured on the rising clock pin, as a codec would
		if (txClockPin === 1'b1 && lastClk === 1'b0)
			txBits <= {txBits[6:0], txDataPin};
		if (txFramePin === 1'b1)
			frames++;
	end
	task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
		@(negedge clk);
	endtask
	task automatic regRead(input logic [3:0] a);
		@(posedge clk);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clk);
		readStrobe <= 1'b0;
		@(negedge clk);
		rd = readData;
	endtask
	task automatic idle(input int cycles);
		repeat (cycles) @(negedge clk);
	endtask
	task automatic printVerdict();
		$display("Comparisons %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		nFail++;
		printVerdict();
	end
	initial
	begin
		reset = 1'b1;
		clkEnable = 1'b1;
		address = 4'h0;
		writeData = 32'h0;
		writeStrobe = 1'b0;
		readStrobe = 1'b0;
		lastDelay = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		idle(1);
		`CHECK(txDataPinOe_n, 1'b1)
		regRead(CTRL);
		`CHECK(rd & 32'h0005_F8BF, 32'h0)
		// Ones into every bit: reserved bits 10-8 and 6 and status bits 18, 2 and 1 must stay clear
		regWrite(CTRL, 32'hFFFF_FFFF);
		regRead(CTRL);
		`CHECK(rd & 32'h0005_FFF7, 32'h0001_F8B1)
		regWrite(CTRL, 32'h0);
		regWrite(CTRL, 32'h0000_0008);
		regRead(CTRL);
		`CHECK(rd[3], 1'b0)
		regWrite(CTRL, 32'h0000_0031);
		n = rxIrqCount;
		regWrite(CTRL, 32'h0000_0039);
		idle(4);
		regRead(CTRL);
		`CHECK(rd[3], 1'b1)
		`CHECK(rxIrqCount - n, 1)
		regWrite(CTRL, 32'h0000_0031);
		regRead(CTRL);
		`CHECK(rd[3], 1'b0)
		regWrite(CTRL, 32'h0001_0080);
		idle(4);
		regRead(CTRL);
		`CHECK(rd[18:17], 2'b01)
		f = frames;
		regWrite(TXD, 32'h0000_00C5);
		regRead(CTRL);
		`CHECK(rd[18], 1'b1)
		`CHECK(txDataPinOe_n, 1'b0)
		idle(150);
		regRead(CTRL);
		`CHECK(rd[18:17], 2'b01)
		`CHECK(txBits, 8'hC5)
		`CHECK(frames - f, 1)
		regWrite(CTRL, 32'h0);
		n = clkEdges;
		f = frames;
		regWrite(TXD, 32'h0000_005C);
		idle(100);
		`CHECK(clkEdges - n, 0)
		`CHECK(frames - f, 0)
		for (int i = 0; i < 8; i++)
		begin
			regWrite(CTRL, 32'h0);
			regWrite(PIN, {31'h0, rows[i].polarity});
			regWrite(CTRL, 32'h0001_8001 | {17'h0, rows[i].justify, rows[i].stopMode, 11'h0});
			idle(4);
			lvl = txClockPin;
			regWrite(TXD, {24'h0, rows[i].word});
			for (k = 0; k < 100 && txClockPin === lvl; k++)
				@(negedge clk);
			if (rows[i].stopMode != 2'h0)
			begin
				`CHECK(txClockPin, rows[i].firstRise)
				if (rows[i].stopMode == 2'h3)
					`CHECK(k > lastDelay, 1'b1)
				lastDelay = k;
			end
			for (k = 0; k < 60; k++)
			begin
				regRead(CTRL);
				if (rd[1] === 1'b1)
					break;
			end
			`CHECK(rd[1], 1'b1)
			regRead(RXD);
			`CHECK(rd, rows[i].rxWord)
		end
		regWrite(PIN, 32'h0);
		regWrite(CTRL, 32'h0000_0010);
		partner.sendWord(8'h33, 0);
		idle(8);
		regRead(CTRL);
		`CHECK(rd[1], 1'b0)
		regWrite(CTRL, 32'h0000_0021);
		regRead(IST);
		n = rxIrqCount;
		partner.sendWord(8'h96, 8);
		idle(8);
		regRead(CTRL);
		`CHECK(rd[1], 1'b1)
		`CHECK(rxIrqCount - n, 1)
		regRead(RXD);
		`CHECK(rd, 32'h0000_0096)
		regRead(CTRL);
		`CHECK(rd[1], 1'b0)
		regRead(IST);
		regWrite(MSK, 32'h0000_0002);
		regWrite(CTRL, 32'h0000_0011);
		n = rxIrqCount;
		partner.sendWord(8'h11, 0);
		partner.sendWord(8'h22, 0);
		partner.sendWord(8'h4E, 0);
		idle(8);
		regRead(CTRL);
		`CHECK(rd[2], 1'b1)
		`CHECK(rxIrqCount - n, 3)
		`CHECK(irq, 1'b1)
		regWrite(MSK, 32'h0);
		idle(2);
		`CHECK(irq, 1'b0)
		regWrite(MSK, 32'h0000_0002);
		idle(2);
		`CHECK(irq, 1'b1)
		regRead(IST);
		`CHECK(rd[serial_port_pkg::IRQ_OVERRUN], 1'b1)
		idle(2);
		`CHECK(irq, 1'b0)
		regRead(RXD);
		`CHECK(rd, 32'h0000_0011)
		// Second reset in mid-run: everything must come back quiet
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		idle(1);
		`CHECK({irq, txDataPinOe_n, readData}, {2'b01, 32'h0})
		regRead(CTRL);
		`CHECK(rd, 32'h0)
		printVerdict();
	end
endmodule
